// *** shared/cidm_pkg.sv ***
`default_nettype none
package cidm_pkg;
  // internal data space sizes
  localparam int unsigned RAM_DEPTH      = 256;
  localparam logic [7:0]  SFR_BASE       = 8'h80;
  localparam logic [7:0]  BIT_RAM_BASE   = 8'h20;
  localparam logic [7:0]  BANK_AREA_TOP  = 8'h1f;
  // reset values and the value read from unimplemented sfrs
  localparam logic [7:0]  STACK_TOP_RESET = 8'h07;
  localparam logic [7:0]  BYTE_RESET     = 8'h00;
  localparam logic [7:0]  UNIMPL_READ    = 8'hff;
  // special function register direct addresses
  localparam logic [7:0]  SFR_STACK_TOP  = 8'h81;
  localparam logic [7:0]  SFR_DPL        = 8'h82;
  localparam logic [7:0]  SFR_DPH        = 8'h83;
  localparam logic [7:0]  SFR_FLAGS      = 8'hd0;
  localparam logic [7:0]  SFR_PRIMARY    = 8'he0;
  localparam logic [7:0]  SFR_B          = 8'hf0;
  // status word field positions
  localparam int unsigned FLG_CY         = 7;
  localparam int unsigned FLG_AC         = 6;
  localparam int unsigned FLG_F0         = 5;
  localparam int unsigned FLG_BANK_HI    = 4;
  localparam int unsigned FLG_BANK_LO    = 3;
  localparam int unsigned FLG_OV         = 2;
  localparam int unsigned FLG_F1         = 1;
  localparam int unsigned FLG_P          = 0;
  // wishbone register map of the block (byte addresses)
  localparam logic [3:0]  WB_CTRL        = 4'h0;
  localparam logic [3:0]  WB_DATA        = 4'h4;
  localparam logic [3:0]  WB_STAT        = 4'h8;
  localparam logic [3:0]  WB_RESULT      = 4'hc;
  // command codes written to the control register
  typedef enum logic [3:0] {
    CIDM_NOP, CIDM_DIR_RD, CIDM_DIR_WR, CIDM_IND_RD, CIDM_IND_WR,
    CIDM_REG_RD, CIDM_REG_WR, CIDM_BIT_RD, CIDM_BIT_WR,
    CIDM_PUSH, CIDM_POP, CIDM_CALL, CIDM_ALU_FLAGS
  } cidm_cmd_type;
endpackage : cidm_pkg
`default_nettype wire

// *** core/cidm_core.sv ***
`default_nettype none
// How it works
// RQ1: a 256 byte scratch-pad ram holds temporary data.
// RQ2: special registers use direct addressing only; ram takes direct and indirect.
// RQ3: ram 80h to ffh is reached only indirectly; direct there means sfr.
// RQ4: four banks of eight 8-bit working registers, each one addressable.
// RQ5: bank n sits at ram n*8 to n*8+7, filling 00h to 1fh.
// RQ6: the two bank select bits in the status word pick the active bank.
// RQ7: registers zero and one of the active bank hold indirect addresses.
// RQ8: ram 20h to 2fh is byte and bit addressable, 128 bits.
// RQ9: bit or byte access is chosen only by the command type.
// RQ10: implemented sfrs at addresses ending 0 or 8 are bit addressable.
// RQ11: 8-bit stack pointer addresses a stack anywhere in scratch-pad ram.
// RQ12: stack pointer resets to 07h and then takes any written value.
// RQ13: push increments the pointer first, then writes at the new address.
// RQ14: pop reads at the current address first, then decrements the pointer.
// RQ15: a call saves its return address on the stack with push ordering.
// RQ16: return address pushed low byte then high byte; pointer wraps mod 256.
// RQ17: an 8-bit second operand register feeds multiply and divide.
// RQ18: status word holds carry, aux carry, overflow, parity, two flags, bank bits.
// RQ19: program and data spaces are separate, each 64k; fetches use program space.
// RQ20: code table read takes constants from program space.
// RQ21: exactly one 16-bit data pointer addresses external data space.
// RQ22: special registers occupy direct addresses 80h to ffh.
// RQ23: unimplemented sfrs and bits read as one.
module cidm_core (
  input  wire logic                 sys_clk_i,     // core clock
  input  wire logic                 srst_i,        // synchronous reset
  input  wire logic [31:0]          wb_adr_i,      // wishbone address
  input  wire logic [31:0]          wb_dat_i,      // wishbone write data
  input  wire logic [3:0]           wb_sel_i,      // byte enables
  input  wire logic                 wb_we_i,       // write enable
  input  wire logic                 wb_cyc_i,      // cycle
  input  wire logic                 wb_stb_i,      // strobe
  output logic      [31:0]          wb_dat_o,      // read data
  output logic                      wb_ack_o,      // acknowledge
  output logic      [15:0]          wide_ext_pointer_o, // external data pointer
  output logic      [7:0]           primary_operand_reg_o, // accumulator
  output logic      [7:0]           second_operand_o,      // multiply/divide operand
  output logic      [7:0]           alu_flag_word_o        // status word
);
  import cidm_pkg::*;

  // storage and core registers
  logic [7:0]   ram_q [RAM_DEPTH];
  logic [7:0]   stack_top_pointer_q;
  logic [7:0]   prim_q;
  logic [7:0]   b_q;
  logic [7:0]   flags_q;
  logic [15:0]  ext_ptr_q;
  logic [7:0]   result_q;
  logic [15:0]  ret_q;
  logic         bad_cmd_q;
  logic         ack_q;
  logic [31:0]  dat_q;

  // bus request fields
  logic         bus_req;
  logic         cmd_wr;
  cidm_cmd_type cmd;
  logic [7:0]   arg_addr;
  logic [7:0]   arg_data;
  logic [2:0]   arg_bit;
  logic         arg_bval;
  logic [15:0]  arg_ret;

  // register offset decode, shared by the command write and the read mux
  function automatic logic at_off(input logic [3:0] a, input logic [3:0] o);
    at_off = (a == o);
  endfunction : at_off

  // ack_q blocks a second take while the master still holds the same cycle
  assign bus_req  = wb_cyc_i && wb_stb_i && !ack_q;
  assign cmd_wr   = bus_req && wb_we_i && at_off(wb_adr_i[3:0], WB_CTRL) && wb_sel_i[0];
  assign cmd      = cidm_cmd_type'(wb_dat_i[3:0]);
  assign arg_addr = wb_dat_i[15:8];
  assign arg_data = wb_dat_i[23:16];
  assign arg_bit  = wb_dat_i[26:24];
  assign arg_bval = wb_dat_i[27];
  assign arg_ret  = wb_dat_i[31:16];

  // working register location: bank select bits times 8 plus index
  function automatic logic [7:0] reg_loc(input logic [7:0] f, input logic [2:0] n);
    // RQ5 bank placement
    // RQ6 bank select
    reg_loc = {3'b000, f[FLG_BANK_HI], f[FLG_BANK_LO], n};
  endfunction : reg_loc

  // bit address to byte location in ram or sfr space
  function automatic logic [7:0] bit_byte(input logic [7:0] ba);
    // RQ8 bit region map
    // RQ10 sfr bit map
    // an sfr bit lands in the byte whose address ends in 0 or 8
    if (ba[7]) begin
      bit_byte = {ba[7:3], 3'b000};
    end else begin
      bit_byte = BIT_RAM_BASE + {4'h0, ba[6:3]};
    end
  endfunction : bit_byte

  // direct read: low half is ram, high half is sfr space
  function automatic logic [7:0] dir_read(
    input logic [7:0] a, input logic [7:0] st, input logic [7:0] pr,
    input logic [7:0] bb, input logic [7:0] fl, input logic [15:0] dp,
    input logic [7:0] rv);
    // RQ2 direct decode
    // RQ22 sfr window
    if (a < SFR_BASE) begin
      dir_read = rv;
    end else if (a == SFR_STACK_TOP) begin
      dir_read = st;
    end else if (a == SFR_DPL) begin
      dir_read = dp[7:0];
    end else if (a == SFR_DPH) begin
      dir_read = dp[15:8];
    end else if (a == SFR_FLAGS) begin
      dir_read = fl;
    end else if (a == SFR_PRIMARY) begin
      dir_read = pr;
    end else if (a == SFR_B) begin
      dir_read = bb;
    end else begin
      // RQ23 unimplemented reads one
      dir_read = UNIMPL_READ;
    end
  endfunction : dir_read

  // effective addresses and data for the current command
  logic [7:0] ind_addr;
  logic [7:0] bit_loc;
  logic [7:0] bit_cur;
  logic [7:0] top_inc;
  logic [7:0] top_inc2;

  // RQ7 indirect pointers
  assign ind_addr = ram_q[reg_loc(flags_q, {2'b00, arg_addr[0]})];
  assign bit_loc  = bit_byte(arg_addr);
  assign bit_cur  = dir_read(bit_loc, stack_top_pointer_q, prim_q, b_q, flags_q, ext_ptr_q,
                             ram_q[bit_loc]);
  // RQ16 pointer wraps
  // 8-bit sums drop the carry, so a push from ffh lands at 00h
  assign top_inc  = stack_top_pointer_q + 8'h01;
  assign top_inc2 = stack_top_pointer_q + 8'h02;

  // bit write is legal on ram bit area or an implemented sfr ending 0 or 8
  logic bit_ok;
  always_comb begin
    // any other sfr byte is missing here or not bit addressable
    // RQ10 bit addressable sfrs
    bit_ok = !arg_addr[7] || (bit_loc == SFR_FLAGS) || (bit_loc == SFR_PRIMARY)
             || (bit_loc == SFR_B);
  end

  // direct write target is ram only below sfr base
  logic cmd_go;
  assign cmd_go = cmd_wr;

  // scratch-pad ram
  // every byte is cleared on reset so no read ever returns an unknown
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < RAM_DEPTH; i++) begin
        // RQ1 ram cleared
        ram_q[i] <= BYTE_RESET;
      end
    end else if (cmd_go) begin
      case (cmd)
        CIDM_DIR_WR: begin
          // RQ3 direct is ram low half
          if (arg_addr < SFR_BASE) begin
            ram_q[arg_addr] <= arg_data;
          end
        end
        CIDM_IND_WR: begin
          // RQ2 indirect reaches all ram
          ram_q[ind_addr] <= arg_data;
        end
        CIDM_REG_WR: begin
          // RQ4 working register write
          ram_q[reg_loc(flags_q, arg_addr[2:0])] <= arg_data;
        end
        CIDM_BIT_WR: begin
          // RQ9 bit access by command
          if (!arg_addr[7]) begin
            ram_q[bit_loc][arg_addr[2:0]] <= arg_bval;
          end
        end
        CIDM_PUSH: begin
          // RQ11 stack anywhere in ram
          // RQ13 write at incremented pointer
          ram_q[top_inc] <= arg_data;
        end
        CIDM_CALL: begin
          // RQ15 return address saved
          // RQ16 low byte then high
          // both bytes land in one edge, so no half-saved address is ever seen
          ram_q[top_inc]  <= arg_ret[7:0];
          ram_q[top_inc2] <= arg_ret[15:8];
        end
        default: begin
        end
      endcase
    end
  end

  // special function registers held in this block
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      // RQ12 pointer reset
      stack_top_pointer_q <= STACK_TOP_RESET;
      prim_q              <= BYTE_RESET;
      b_q                 <= BYTE_RESET;
      flags_q             <= BYTE_RESET;
      ext_ptr_q           <= {2{BYTE_RESET}};
    end else if (cmd_go) begin
      case (cmd)
        CIDM_DIR_WR: begin
          // writes to missing sfrs match no branch and are dropped
          // RQ12 software writes pointer
          if (arg_addr == SFR_STACK_TOP) begin
            stack_top_pointer_q <= arg_data;
          end else if (arg_addr == SFR_DPL) begin
            // RQ21 single data pointer
            ext_ptr_q[7:0] <= arg_data;
          end else if (arg_addr == SFR_DPH) begin
            ext_ptr_q[15:8] <= arg_data;
          end else if (arg_addr == SFR_FLAGS) begin
            flags_q <= arg_data;
          end else if (arg_addr == SFR_PRIMARY) begin
            prim_q <= arg_data;
          end else if (arg_addr == SFR_B) begin
            // RQ17 second operand
            b_q <= arg_data;
          end
        end
        CIDM_BIT_WR: begin
          if (arg_addr[7] && bit_ok) begin
            if (bit_loc == SFR_FLAGS) begin
              flags_q[arg_addr[2:0]] <= arg_bval;
            end else if (bit_loc == SFR_PRIMARY) begin
              prim_q[arg_addr[2:0]] <= arg_bval;
            end else begin
              b_q[arg_addr[2:0]] <= arg_bval;
            end
          end
        end
        CIDM_PUSH: begin
          // RQ13 increment first
          stack_top_pointer_q <= top_inc;
        end
        CIDM_POP: begin
          // RQ14 decrement after read
          stack_top_pointer_q <= stack_top_pointer_q - 8'h01;
        end
        CIDM_CALL: begin
          stack_top_pointer_q <= top_inc2;
        end
        CIDM_ALU_FLAGS: begin
          // the two general flags and the bank bits keep what software wrote
          // RQ18 alu result flags
          flags_q[FLG_CY] <= arg_data[FLG_CY];
          flags_q[FLG_AC] <= arg_data[FLG_AC];
          flags_q[FLG_OV] <= arg_data[FLG_OV];
          // parity is taken from the primary operand as it stands before this edge
          flags_q[FLG_P]  <= ^prim_q;
        end
        default: begin
        end
      endcase
    end
  end

  // command result and refusal flag
  // the refusal flag holds until the next command replaces it
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      result_q  <= BYTE_RESET;
      bad_cmd_q <= 1'b0;
    end else if (cmd_go) begin
      bad_cmd_q <= 1'b0;
      case (cmd)
        CIDM_DIR_RD: begin
          result_q <= dir_read(arg_addr, stack_top_pointer_q, prim_q, b_q, flags_q,
                               ext_ptr_q, ram_q[arg_addr]);
        end
        CIDM_IND_RD: begin
          result_q <= ram_q[ind_addr];
        end
        CIDM_REG_RD: begin
          result_q <= ram_q[reg_loc(flags_q, arg_addr[2:0])];
        end
        CIDM_BIT_RD: begin
          // RQ23 missing bit reads one
          result_q <= {7'h00, bit_ok ? bit_cur[arg_addr[2:0]] : 1'b1};
        end
        CIDM_POP: begin
          // the same edge moves the pointer, but this read uses its old value
          // RQ14 read before decrement
          result_q <= ram_q[stack_top_pointer_q];
        end
        CIDM_BIT_WR: begin
          bad_cmd_q <= !bit_ok;
        end
        default: begin
        end
      endcase
    end
  end

  // wishbone slave: one wait state, ack for one cycle
  // read data is captured at the taking edge and stands with ack
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ack_q <= 1'b0;
      dat_q <= {4{BYTE_RESET}};
    end else begin
      ack_q <= bus_req;
      if (bus_req && !wb_we_i) begin
        if (at_off(wb_adr_i[3:0], WB_CTRL)) begin
          dat_q <= 32'h0000_0000;
        end else if (at_off(wb_adr_i[3:0], WB_DATA)) begin
          dat_q <= {24'h000000, result_q};
        end else if (at_off(wb_adr_i[3:0], WB_STAT)) begin
          dat_q <= {7'h00, bad_cmd_q, ext_ptr_q, stack_top_pointer_q};
        end else if (at_off(wb_adr_i[3:0], WB_RESULT)) begin
          dat_q <= {flags_q, b_q, prim_q, stack_top_pointer_q};
        end else begin
          dat_q <= 32'h0000_0000;
        end
      end
    end
  end

  // RQ19 separate spaces: this block holds only internal data space
  // RQ20 code table reads are not served here; this block has no program space port
  assign wb_ack_o              = ack_q;
  assign wb_dat_o              = dat_q;
  assign wide_ext_pointer_o    = ext_ptr_q;
  assign primary_operand_reg_o = prim_q;
  assign second_operand_o      = b_q;
  assign alu_flag_word_o       = flags_q;
endmodule : cidm_core
`default_nettype wire

// *** tb/cidm_core_properties.sv ***
`default_nettype none
module cidm_core_props
  import cidm_pkg::*;
(
  input wire logic        sys_clk_i,             // clock
  input wire logic        srst_i,                // reset
  input wire logic [31:0] wb_adr_i,              // address
  input wire logic        wb_we_i,               // write
  input wire logic        wb_cyc_i,              // cycle
  input wire logic        wb_stb_i,              // strobe
  input wire logic [31:0] wb_dat_o,              // read data
  input wire logic        wb_ack_o,              // ack
  input wire logic [15:0] wide_ext_pointer_o,    // pointer
  input wire logic [7:0]  primary_operand_reg_o, // primary operand
  input wire logic [7:0]  second_operand_o,      // b
  input wire logic [7:0]  alu_flag_word_o        // flags
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // request decode seen from the bus
  logic take, ctl_wr, rd_stat, rd_res, rd_bad;
  assign take    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign ctl_wr  = take && wb_we_i && wb_adr_i[3:0] == WB_CTRL;
  assign rd_stat = take && !wb_we_i && wb_adr_i[3:0] == WB_STAT;
  assign rd_res  = take && !wb_we_i && wb_adr_i[3:0] == WB_RESULT;
  assign rd_bad  = take && !wb_we_i && wb_adr_i[1:0] != 2'h0;
  a_ack_after_take: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse after request");
  a_ack_needs_take: assert property (wb_ack_o |-> $past(take))
    else $error("ack without request");
  a_reset_clears: assert property ($fell(srst_i) |->
    {wide_ext_pointer_o, primary_operand_reg_o, second_operand_o, alu_flag_word_o} == 40'h0)
    else $error("outputs not cleared by reset");
  a_flags_by_cmd: assert property ($changed(alu_flag_word_o) |-> $past(ctl_wr) || $past(srst_i))
    else $error("flags changed without command");
  a_b_by_cmd: assert property (!$past(ctl_wr) && !$past(srst_i) |-> $stable(second_operand_o))
    else $error("operand changed without command");
  a_pointer_by_cmd: assert property ($changed(wide_ext_pointer_o) |-> $past(ctl_wr) || $past(srst_i))
    else $error("pointer changed without command");
  a_stat_pointer: assert property (wb_ack_o && $past(rd_stat) |->
    wb_dat_o[23:8] == $past(wide_ext_pointer_o))
    else $error("status read pointer wrong");
  a_result_regs: assert property (wb_ack_o && $past(rd_res) |-> wb_dat_o[31:8] ==
    {$past(alu_flag_word_o), $past(second_operand_o), $past(primary_operand_reg_o)})
    else $error("result read registers wrong");
  a_unmapped_zero: assert property (wb_ack_o && $past(rd_bad) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  c_ctl_wr: cover property (ctl_wr);
  c_res_rd: cover property (wb_ack_o && $past(rd_res));
  c_pointer: cover property ($changed(wide_ext_pointer_o));
endmodule : cidm_core_props
bind cidm_core cidm_core_props chk_u (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .wide_ext_pointer_o(wide_ext_pointer_o), .primary_operand_reg_o(primary_operand_reg_o),
  .second_operand_o(second_operand_o), .alu_flag_word_o(alu_flag_word_o));
`default_nettype wire

// *** tb/cidm_seq_model.sv ***
`default_nettype none
module cidm_seq_model (
  input  wire logic        sys_clk_i, // clock
  input  wire logic [31:0] wb_dat_i,  // read data
  input  wire logic        wb_ack_i,  // ack
  output var  logic [31:0] wb_adr_o,  // address
  output var  logic [31:0] wb_dat_o,  // write data
  output var  logic [3:0]  wb_sel_o,  // byte enables
  output var  logic        wb_we_o,   // write
  output var  logic        wb_cyc_o,  // cycle
  output var  logic        wb_stb_o   // strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    wb_adr_o = 32'h0;
    wb_dat_o = 32'h0;
    wb_sel_o = 4'h0;
    wb_we_o  = 1'b0;
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
  end
  // one classic cycle, held until ack is sampled at a rising edge, then released there
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    @(posedge sys_clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= w;
    wb_adr_o <= {28'h0, a};
    wb_dat_o <= d;
    wb_sel_o <= 4'hf;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (wb_ack_i !== 1'b1 && n < 64);
    ok = (wb_ack_i === 1'b1);
    q  = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o  <= 1'b0;
    // released lines must not keep the old value
    wb_adr_o <= ~wb_adr_o;
    wb_dat_o <= ~wb_dat_o;
  endtask : xfer
endmodule : cidm_seq_model
`default_nettype wire

// *** tb/test_core_internal_data_memory.sv ***
`default_nettype none
module test_core_internal_data_memory import cidm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk_i, srst_i, wb_we, wb_cyc, wb_stb, wb_ack;
  logic [31:0] wb_adr, wb_wdat, wb_rdat, q;
  logic [3:0]  wb_sel;
  logic [15:0] dp;
  logic [7:0]  prim, bb, fl, r;
  int          error_cnt = 0;
  int          cmp_count = 0;
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  cidm_core dut_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .wb_adr_i(wb_adr),
    .wb_dat_i(wb_wdat), .wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .wide_ext_pointer_o(dp),
    .primary_operand_reg_o(prim), .second_operand_o(bb), .alu_flag_word_o(fl));
  cidm_seq_model seq_u (.sys_clk_i(sys_clk_i), .wb_dat_i(wb_rdat), .wb_ack_i(wb_ack),
    .wb_adr_o(wb_adr), .wb_dat_o(wb_wdat), .wb_sel_o(wb_sel), .wb_we_o(wb_we),
    .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb));
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t byte %h not %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t word %h not %h", $time, g, e);
    end
  endtask : chk32
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    logic ok;
    seq_u.xfer(w, a, d, q, ok);
    if (!ok) begin
      error_cnt++;
      $display("MISMATCH %0t no ack", $time);
      test_done();
    end
  endtask : bus
  // command write, then its result byte
  task automatic op(input cidm_cmd_type c, input logic [7:0] a, input logic [7:0] d,
                    input logic b = 1'b0);
    bus(1'b1, WB_CTRL, {4'h0, b, 3'h0, d, a, 4'h0, c});
    bus(1'b0, WB_DATA, 32'h0);
    r = q[7:0];
  endtask : op
  task automatic s_reset;
    bus(1'b0, WB_RESULT, 32'h0);
    chk32(q, {24'h0, STACK_TOP_RESET});
    chk32({dp, bb, prim}, 32'h0);
  endtask : s_reset
  // reset in mid-run, after every register has been given a value
  task automatic s_rerun;
    @(posedge sys_clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    s_reset();
    op(CIDM_DIR_RD, 8'h31, 8'h0);
    chk8(r, BYTE_RESET);
  endtask : s_rerun
  task automatic s_banks;
    for (int b = 0; b < 4; b++) begin
      op(CIDM_DIR_WR, SFR_FLAGS, 8'(b << FLG_BANK_LO));
      chk8(fl, 8'(b << FLG_BANK_LO));
      op(CIDM_REG_WR, 8'h5, 8'h50 + 8'(b));
    end
    op(CIDM_REG_RD, 8'h5, 8'h0);
    chk8(r, 8'h53);
    for (int b = 0; b < 4; b++) begin
      op(CIDM_DIR_RD, 8'(b * 8 + 5), 8'h0);
      chk8(r, 8'h50 + 8'(b));
    end
  endtask : s_banks
  task automatic s_indirect;
    op(CIDM_DIR_WR, SFR_FLAGS, 8'h00);
    op(CIDM_REG_WR, 8'h0, 8'h90);
    op(CIDM_REG_WR, 8'h1, 8'hc3);
    op(CIDM_IND_WR, 8'h0, 8'ha5);
    op(CIDM_IND_WR, 8'h1, 8'h3c);
    op(CIDM_DIR_WR, 8'h90, 8'h77);
    op(CIDM_DIR_RD, 8'h90, 8'h0);
    chk8(r, UNIMPL_READ);
    op(CIDM_IND_RD, 8'h0, 8'h0);
    chk8(r, 8'ha5);
    op(CIDM_IND_RD, 8'h1, 8'h0);
    chk8(r, 8'h3c);
  endtask : s_indirect
  task automatic s_bits;
    op(CIDM_BIT_WR, 8'h0b, 8'h0, 1'b1);
    op(CIDM_DIR_RD, 8'h21, 8'h0);
    chk8(r, 8'h08);
    op(CIDM_BIT_RD, 8'h0b, 8'h0);
    chk8(r, 8'h01);
    op(CIDM_BIT_WR, 8'he1, 8'h0, 1'b1);
    chk8(prim, 8'h02);
    op(CIDM_BIT_WR, 8'h88, 8'h0, 1'b1);
    bus(1'b0, WB_STAT, 32'h0);
    chk8(8'(q[24]), 8'h01);
    op(CIDM_BIT_RD, 8'h90, 8'h0);
    chk8(r, 8'h01);
  endtask : s_bits
  // push across the top of ram, then pop back
  task automatic s_stack;
    op(CIDM_DIR_WR, SFR_STACK_TOP, 8'hfe);
    op(CIDM_PUSH, 8'h0, 8'h11);
    op(CIDM_PUSH, 8'h0, 8'h22);
    bus(1'b0, WB_RESULT, 32'h0);
    chk8(q[7:0], 8'h00);
    op(CIDM_DIR_RD, 8'h00, 8'h0);
    chk8(r, 8'h22);
    op(CIDM_POP, 8'h0, 8'h0);
    chk8(r, 8'h22);
    op(CIDM_POP, 8'h0, 8'h0);
    chk8(r, 8'h11);
    bus(1'b0, WB_RESULT, 32'h0);
    chk8(q[7:0], 8'hfe);
  endtask : s_stack
  task automatic s_call;
    op(CIDM_DIR_WR, SFR_STACK_TOP, 8'h30);
    bus(1'b1, WB_CTRL, {16'hbeef, 12'h0, CIDM_CALL});
    op(CIDM_DIR_RD, 8'h31, 8'h0);
    chk8(r, 8'hef);
    op(CIDM_DIR_RD, 8'h32, 8'h0);
    chk8(r, 8'hbe);
  endtask : s_call
  task automatic s_regs;
    op(CIDM_DIR_WR, SFR_DPL, 8'h34);
    op(CIDM_DIR_WR, SFR_DPH, 8'h12);
    chk32(32'(dp), 32'h1234);
    op(CIDM_DIR_WR, SFR_PRIMARY, 8'h97);
    op(CIDM_DIR_WR, SFR_B, 8'h5a);
    op(CIDM_ALU_FLAGS, 8'h0, 8'hc4);
    bus(1'b0, WB_RESULT, 32'h0);
    chk32(q, {8'hc4 | 8'(^8'h97), 8'h5a, 8'h97, 8'h32});
    op(CIDM_DIR_RD, SFR_B, 8'h0);
    chk8(r, 8'h5a);
    op(CIDM_DIR_RD, 8'h85, 8'h0);
    chk8(r, UNIMPL_READ);
    bus(1'b0, 4'h2, 32'h0);
    chk32(q, 32'h0);
  endtask : s_regs
  initial begin
    srst_i = 1'b1;
    repeat (5) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    s_reset();
    s_banks();
    s_indirect();
    s_bits();
    s_stack();
    s_call();
    s_regs();
    s_rerun();
    test_done();
  end
endmodule : test_core_internal_data_memory
`default_nettype wire
